// ===== shared/off_delay_pkg.sv
// Constants shared by the off-delay timer block
package off_delay_pkg;
    // =====================================================================
    // Register map (byte addresses, one aligned word each)
    // =====================================================================
    localparam logic [7:0] ADDR_CTRL      = 8'h00; // Run bit (bit 0)
    localparam logic [7:0] ADDR_FIX_DELAY = 8'h04; // Fixed delay in 10 ms steps
    localparam logic [7:0] ADDR_STAGE0    = 8'h08; // Adjustable stage 1..4
    localparam logic [7:0] ADDR_STAGE1    = 8'h0C;
    localparam logic [7:0] ADDR_STAGE2    = 8'h10;
    localparam logic [7:0] ADDR_STAGE3    = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18; // Outputs and config error

    // =====================================================================
    // Field layout
    // =====================================================================
    localparam int CTRL_RUN_BIT   = 0;
    localparam int ST_FIXOUT_BIT  = 0;
    localparam int ST_ADJOUT_BIT  = 1;
    localparam int ST_CHG_BIT     = 2;
    localparam int ST_CFGERR_BIT  = 3;
    localparam int ST_FIXRUN_BIT  = 4;
    localparam int ST_ADJRUN_BIT  = 5;
    localparam int DELAY_W        = 16;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_HZ         = 25_000_000;
    localparam int TICK_MS        = 10;
    localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    localparam int FIX_MAX_S      = 300;
    localparam int ADJ_MAX_S      = 600;
    localparam logic [DELAY_W-1:0] FIX_MAX_STEPS = DELAY_W'(FIX_MAX_S * 1000 / TICK_MS);
    localparam logic [DELAY_W-1:0] ADJ_MAX_STEPS = DELAY_W'(ADJ_MAX_S * 1000 / TICK_MS);
    localparam int NUM_STAGES     = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/off_delay_core.sv
// Off-delay sequencer, instantiated once for the fixed and once for the adjustable variant
module off_delay_core
    import off_delay_pkg::*;
#(
    parameter int W = DELAY_W
) (
    input  wire logic         core_clk,   // System clock
    input  wire logic         sys_rst,    // Async reset, active high
    input  wire logic         runMode,    // Controller in run state
    input  wire logic         evalStrobe, // Logic execution cycle
    input  wire logic         stepTick,   // 10 ms tick, qualified
    input  wire logic         ctrlIn,     // Control input, synchronised
    input  wire logic [W-1:0] delaySteps, // Delay latched at the falling edge
    output logic              enableOut,  // Delayed output
    output logic              running,    // Sequence in progress
    output logic              fallEdge    // Falling edge seen this cycle
);
    typedef struct packed {
        logic         prevIn;
        logic         firstCycle;
        logic         out;
        logic         busy;
        logic [W-1:0] count;
        logic [W-1:0] target;
    } core_state_type;

    core_state_type state_reg, state_next;

    // =====================================================================
    // Sequencer
    // =====================================================================
    always_comb begin
        state_next = state_reg;
        fallEdge = 1'b0;
        if (!runMode) begin
            state_next.firstCycle = 1'b1;
            state_next.busy = 1'b0;
            state_next.count = '0;
        end else if (evalStrobe) begin
            state_next.prevIn = ctrlIn;
            state_next.firstCycle = 1'b0;
            if (state_reg.firstCycle) begin
                state_next.out = ctrlIn;
            end else if (ctrlIn) begin
                state_next.out = 1'b1;
                state_next.busy = 1'b0;
                state_next.count = '0;
            end else if (state_reg.prevIn) begin
                fallEdge = 1'b1;
                state_next.target = delaySteps;
                state_next.count = '0;
                if (delaySteps == '0) begin
                    state_next.out = 1'b0;
                end else begin
                    state_next.busy = 1'b1;
                end
            end else if (state_reg.busy) begin
                if (stepTick) begin
                    state_next.count = state_reg.count + W'(1);
                end
                if (state_next.count >= state_reg.target) begin
                    state_next.out = 1'b0;
                    state_next.busy = 1'b0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign enableOut = state_reg.out;
    assign running = state_reg.busy;
endmodule

// ===== hw/off_delay_timer_block.sv
// Off-delay timer block, fixed and adjustable variants, AXI4-Lite registers
//
// Our own choices: the register addresses and the AXI4-Lite register port.
module off_delay_timer_block
    import off_delay_pkg::*;
#(
    parameter int TICK_DIV  = TICK_CYCLES, // Cycles per 10 ms
    parameter int EVAL_DIV  = 8'h04        // Cycles per logic execution cycle
) (
    input  wire logic                  core_clk,       // 25 MHz clock
    input  wire logic                  sys_rst,        // Async reset, active high
    input  wire logic                  fixInPin,       // Fixed-variant input
    input  wire logic                  ctrlInPin,      // Adjustable control input
    input  wire logic [NUM_STAGES-1:0] selPins,        // Stage select inputs
    output logic                       fixEnable,      // Fixed-variant output
    output logic                       adjEnable,      // Adjustable output
    output logic                       timeChanged,    // Select changed in sequence
    input  wire logic [7:0]            s_axi_awaddr,   // Write address
    input  wire logic                  s_axi_awvalid,  // Write address valid
    output logic                       s_axi_awready,  // Write address ready
    input  wire logic [31:0]           s_axi_wdata,    // Write data
    input  wire logic [3:0]            s_axi_wstrb,    // Write strobes
    input  wire logic                  s_axi_wvalid,   // Write data valid
    output logic                       s_axi_wready,   // Write data ready
    output logic [1:0]                 s_axi_bresp,    // Write response
    output logic                       s_axi_bvalid,   // Write response valid
    input  wire logic                  s_axi_bready,   // Write response ready
    input  wire logic [7:0]            s_axi_araddr,   // Read address
    input  wire logic                  s_axi_arvalid,  // Read address valid
    output logic                       s_axi_arready,  // Read address ready
    output logic [31:0]                s_axi_rdata,    // Read data
    output logic [1:0]                 s_axi_rresp,    // Read response
    output logic                       s_axi_rvalid,   // Read data valid
    input  wire logic                  s_axi_rready    // Read data ready
);
    localparam int PIN_W = 2 + NUM_STAGES;

    typedef struct packed {
        logic [PIN_W-1:0]   sync1;
        logic [PIN_W-1:0]   sync2;
        logic [31:0]        tickCnt;
        logic [31:0]        evalCnt;
        logic               run;
        logic [DELAY_W-1:0] fixDelay;
        logic [NUM_STAGES-1:0][DELAY_W-1:0] stage;
        logic [NUM_STAGES-1:0] selLatch;
        logic               tickPend;
        logic               changed;
        logic               awHave;
        logic [7:0]         awAddr;
        logic               wHave;
        logic [31:0]        wData;
        logic [3:0]         wStrb;
        logic               bValid;
        logic [1:0]         bResp;
        logic               rValid;
        logic [31:0]        rData;
        logic [1:0]         rResp;
    } top_state_type;

    top_state_type state_reg, state_next;

    logic               fixIn, ctrlIn, evalStrobe, stepTick;
    logic [NUM_STAGES-1:0] selIn;
    logic [DELAY_W-1:0] adjSum, fixSteps;
    logic               cfgError;
    logic               fixRun, adjRun, adjFall;

    // Merge strobe bytes into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Stage index for an address, NUM_STAGES when not a stage
    function automatic int stageIdx(input logic [7:0] addr);
        int idx;
        idx = NUM_STAGES;
        if (addr >= ADDR_STAGE0 && addr <= ADDR_STAGE3 && addr[1:0] == 2'h0) begin
            idx = int'((addr - ADDR_STAGE0) >> 2);
        end
        return idx;
    endfunction

    // =====================================================================
    // Synchronised pins and delay sums
    // =====================================================================
    assign fixIn = state_reg.sync2[0];
    assign ctrlIn = state_reg.sync2[1];
    assign selIn = state_reg.sync2[PIN_W-1:2];
    assign evalStrobe = (state_reg.evalCnt == 32'h0);

    // Ticks pend until the next evaluation cycle consumes them
    assign stepTick = evalStrobe && state_reg.tickPend;

    // Sum of selected stages: live selects while idle, captured ones while running
    always_comb begin
        logic [DELAY_W+2:0] acc;
        logic [DELAY_W+2:0] all;
        acc = '0;
        all = '0;
        for (int i = 0; i < NUM_STAGES; i++) begin
            all = all + (DELAY_W+3)'(state_reg.stage[i]);
            if (adjRun ? state_reg.selLatch[i] : selIn[i]) begin
                acc = acc + (DELAY_W+3)'(state_reg.stage[i]);
            end
        end
        cfgError = (all > (DELAY_W+3)'(ADJ_MAX_STEPS));
        adjSum = cfgError ? '0 : acc[DELAY_W-1:0];
    end

    // Fixed delay clamped to its range
    assign fixSteps = (state_reg.fixDelay > FIX_MAX_STEPS) ? FIX_MAX_STEPS
                                                          : state_reg.fixDelay;

    // =====================================================================
    // Sequencers
    // =====================================================================
    off_delay_core #(.W(DELAY_W)) fixCore (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .runMode    (state_reg.run),
        .evalStrobe (evalStrobe),
        .stepTick   (stepTick),
        .ctrlIn     (fixIn),
        .delaySteps (fixSteps),
        .enableOut  (fixEnable),
        .running    (fixRun),
        .fallEdge   ()
    );

    off_delay_core #(.W(DELAY_W)) adjCore (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .runMode    (state_reg.run),
        .evalStrobe (evalStrobe),
        .stepTick   (stepTick),
        .ctrlIn     (ctrlIn),
        .delaySteps (adjSum),
        .enableOut  (adjEnable),
        .running    (adjRun),
        .fallEdge   (adjFall)
    );

    assign timeChanged = state_reg.changed;

    // =====================================================================
    // Next state: pins, ticks, flags, AXI4-Lite slave
    // =====================================================================
    always_comb begin
        int          si;
        logic [31:0] rd;
        logic [31:0] mw;
        si = NUM_STAGES;
        rd = 32'h0;
        mw = 32'h0;
        state_next = state_reg;
        state_next.sync1 = {selPins, ctrlInPin, fixInPin};
        state_next.sync2 = state_reg.sync1;

        // Tick and evaluation dividers, a new tick wins over its consumption
        if (stepTick) begin
            state_next.tickPend = 1'b0;
        end
        if (state_reg.tickCnt >= 32'(TICK_DIV - 1)) begin
            state_next.tickCnt = 32'h0;
            state_next.tickPend = 1'b1;
        end else begin
            state_next.tickCnt = state_reg.tickCnt + 32'h1;
        end
        if (state_reg.evalCnt >= 32'(EVAL_DIV - 1)) begin
            state_next.evalCnt = 32'h0;
        end else begin
            state_next.evalCnt = state_reg.evalCnt + 32'h1;
        end

        // Select capture and change flag
        if (adjFall) begin
            state_next.selLatch = selIn;
        end
        if (evalStrobe && ctrlIn) begin
            state_next.changed = 1'b0;
        end else if (evalStrobe && adjRun && selIn != state_reg.selLatch) begin
            state_next.changed = 1'b1;
        end
        if (!state_reg.run) begin
            state_next.changed = 1'b0;
        end

        // Write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.awHave = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.wHave = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end
        if (state_reg.awHave && state_reg.wHave && !state_reg.bValid) begin
            state_next.awHave = 1'b0;
            state_next.wHave = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = RESP_OKAY;
            si = stageIdx(state_reg.awAddr);
            if (state_reg.awAddr == ADDR_CTRL) begin
                mw = merge(32'(state_reg.run), state_reg.wData, state_reg.wStrb);
                state_next.run = mw[CTRL_RUN_BIT];
            end else if (state_reg.awAddr == ADDR_FIX_DELAY) begin
                mw = merge(32'(state_reg.fixDelay), state_reg.wData, state_reg.wStrb);
                state_next.fixDelay = mw[DELAY_W-1:0];
            end else if (si < NUM_STAGES) begin
                mw = merge(32'(state_reg.stage[si]), state_reg.wData, state_reg.wStrb);
                state_next.stage[si] = mw[DELAY_W-1:0];
            end else if (state_reg.awAddr != ADDR_STATUS) begin
                state_next.bResp = RESP_SLVERR;
            end
        end
        if (state_reg.bValid && s_axi_bready) begin
            state_next.bValid = 1'b0;
        end

        // Read channel
        if (s_axi_arvalid && s_axi_arready) begin
            si = stageIdx(s_axi_araddr);
            state_next.rResp = RESP_OKAY;
            if (s_axi_araddr == ADDR_CTRL) begin
                rd[CTRL_RUN_BIT] = state_reg.run;
            end else if (s_axi_araddr == ADDR_FIX_DELAY) begin
                rd[DELAY_W-1:0] = state_reg.fixDelay;
            end else if (si < NUM_STAGES) begin
                rd[DELAY_W-1:0] = state_reg.stage[si];
            end else if (s_axi_araddr == ADDR_STATUS) begin
                rd[ST_FIXOUT_BIT] = fixEnable;
                rd[ST_ADJOUT_BIT] = adjEnable;
                rd[ST_CHG_BIT] = state_reg.changed;
                rd[ST_CFGERR_BIT] = cfgError;
                rd[ST_FIXRUN_BIT] = fixRun;
                rd[ST_ADJRUN_BIT] = adjRun;
            end else begin
                state_next.rResp = RESP_SLVERR;
            end
            state_next.rData = rd;
            state_next.rValid = 1'b1;
        end else if (state_reg.rValid && s_axi_rready) begin
            state_next.rValid = 1'b0;
        end
    end

    // Handshake outputs
    assign s_axi_awready = !state_reg.awHave;
    assign s_axi_wready = !state_reg.wHave;
    assign s_axi_arready = !state_reg.rValid;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = state_reg.rResp;

    // State register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ===== verification/off_delay_chk.sv
// Concurrent checks on the ports of the off-delay timer block
module off_delay_chk
    import off_delay_pkg::*;
(
    input wire logic        core_clk,      // Clock
    input wire logic        sys_rst,       // Async reset
    input wire logic        fixInPin,      // Fixed input
    input wire logic        ctrlInPin,     // Control input
    input wire logic        fixEnable,     // Fixed output
    input wire logic        adjEnable,     // Adjustable output
    input wire logic        timeChanged,   // Change flag
    input wire logic [7:0]  s_axi_awaddr,  // Write address
    input wire logic        s_axi_awvalid, // Address valid
    input wire logic        s_axi_awready, // Address ready
    input wire logic [31:0] s_axi_wdata,   // Write data
    input wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input wire logic        s_axi_wvalid,  // Data valid
    input wire logic        s_axi_wready,  // Data ready
    input wire logic        s_axi_bvalid   // Response valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic runFlag; // Mirror of the run bit
    wire wrHit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    // =====================================================================
    // Helper: run bit seen on combined writes
    // =====================================================================
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            runFlag <= 1'b0;
        end else if (wrHit && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
            runFlag <= s_axi_wdata[CTRL_RUN_BIT];
        end
    end

    // =====================================================================
    // Sequences and assertions
    // =====================================================================
    sequence ctrlLowLong;
        (!ctrlInPin)[*6];
    endsequence
    sequence ctrlHighRun;
        (runFlag && ctrlInPin)[*8];
    endsequence

    a_fix_high_follow: assert property ((runFlag && fixInPin)[*8] |=> ##1 fixEnable)
        else $error("fixed output not high");
    a_adj_high_follow: assert property (ctrlHighRun |=> ##1 adjEnable)
        else $error("adjustable output not high");
    a_chg_cleared: assert property (ctrlHighRun |=> ##1 !timeChanged)
        else $error("change flag not cleared");
    a_fix_drop_cause: assert property ($fell(fixEnable) |-> !$past(fixInPin, 3))
        else $error("fixed output dropped with input high");
    a_adj_drop_cause: assert property ($fell(adjEnable) |-> !$past(ctrlInPin, 3))
        else $error("adjustable output dropped with control high");
    a_chg_flag_holds: assert property (ctrlLowLong ##0 timeChanged |=> timeChanged)
        else $error("change flag lost while control low");
    a_stop_outputs_hold: assert property ((!runFlag)[*3] |=> $stable(fixEnable) && $stable(adjEnable))
        else $error("outputs moved in stop state");
    a_write_answered: assert property (wrHit |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
endmodule

bind off_delay_timer_block off_delay_chk u_off_delay_chk (
    .core_clk, .sys_rst, .fixInPin, .ctrlInPin, .fixEnable, .adjEnable, .timeChanged,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid
);

// ===== verification/off_delay_source.sv
// Model of the preceding safety logic that drives the timer inputs
module off_delay_source (
    input  wire logic  core_clk,  // Clock
    output logic       fixInPin,  // Fixed-variant input
    output logic       ctrlInPin, // Control input
    output logic [3:0] selPins    // Stage selects
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels start low and change only just after a clock edge
    initial begin
        fixInPin = 1'b0;
        ctrlInPin = 1'b0;
        selPins = 4'h0;
    end
    task automatic put(input logic f, input logic c, input logic [3:0] s);
        @(posedge core_clk);
        fixInPin <= f;
        ctrlInPin <= c;
        selPins <= s;
    endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the off-delay timer block
module testbench
    import off_delay_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TD = 10; // Clocks per 10 ms step in simulation
    logic core_clk = 1'b0, sys_rst = 1'b1;
    logic fixInPin, ctrlInPin, fixEnable, adjEnable, timeChanged;
    logic [3:0] selPins, s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int failures = 0, n_compared = 0, cycles = 0;

    off_delay_timer_block #(.TICK_DIV(TD), .EVAL_DIV(4)) u_off_delay_timer_block (
        .core_clk, .sys_rst, .fixInPin, .ctrlInPin, .selPins, .fixEnable, .adjEnable,
        .timeChanged, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    off_delay_source u_off_delay_source (.core_clk, .fixInPin, .ctrlInPin, .selPins);

    // Clock and hang guard
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1; // Outputs settled after the edge that launched them
    endtask
    task automatic src(input logic f, input logic c, input logic [3:0] s);
        u_off_delay_source.put(f, c, s);
    endtask

    // =====================================================================
    // Register bus master
    // =====================================================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic da, dw, db;
        logic [1:0] r;
        da = 1'b0;
        dw = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge core_clk);
            da = da | s_axi_awready;
            dw = dw | s_axi_wready;
            @(posedge core_clk);
            if (da) s_axi_awvalid <= 1'b0;
            if (dw) s_axi_wvalid <= 1'b0;
        end while (!(da && dw));
        s_axi_bready <= 1'b1;
        do begin
            @(negedge core_clk);
            db = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
        end while (!db);
        s_axi_bready <= 1'b0;
        chk(r === er, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        logic dr, dv;
        logic [1:0] r;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge core_clk);
            dr = s_axi_arready;
            @(posedge core_clk);
        end while (!dr);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            dv = s_axi_rvalid;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge core_clk);
        end while (!dv);
        s_axi_rready <= 1'b0;
        chk(r === er, "read response");
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_regs;
        rd(ADDR_CTRL, RESP_OKAY, rdat);
        chk(rdat === 32'h0, "run bit after reset");
        rd(8'h40, RESP_SLVERR, rdat);
        chk(rdat === 32'h0, "unmapped read data");
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hFF, RESP_OKAY);
        wr(ADDR_FIX_DELAY, 32'h7530, RESP_OKAY);
        rd(ADDR_FIX_DELAY, RESP_OKAY, rdat);
        chk(rdat === 32'h7530, "longest delay");
        wr(ADDR_FIX_DELAY, 32'h7531, RESP_OKAY);
        rd(ADDR_FIX_DELAY, RESP_OKAY, rdat);
        chk(rdat === 32'h7531, "raw delay kept");
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    endtask
    task automatic t_fix;
        wr(ADDR_FIX_DELAY, 32'h5, RESP_OKAY);
        src(1'b1, 1'b1, 4'h0);
        cyc(12);
        chk(fixEnable === 1'b1, "fixed output high");
        src(1'b0, 1'b1, 4'h0);
        cyc(35);
        chk(fixEnable === 1'b1, "fixed output early low");
        src(1'b1, 1'b1, 4'h0);
        cyc(10);
        src(1'b0, 1'b1, 4'h0);
        cyc(35);
        chk(fixEnable === 1'b1, "count not cleared");
        cyc(40);
        chk(fixEnable === 1'b0, "fixed output stuck high");
        wr(ADDR_FIX_DELAY, 32'h0, RESP_OKAY);
        src(1'b1, 1'b1, 4'h0);
        cyc(12);
        src(1'b0, 1'b1, 4'h0);
        cyc(10);
        chk(fixEnable === 1'b0, "zero delay not passed");
    endtask
    task automatic t_adj;
        for (int i = 0; i < 4; i++) wr(ADDR_STAGE0 + 8'(4 * i), 32'(i + 2), RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            src(1'b0, 1'b1, 4'(1 << i));
            cyc(12);
            src(1'b0, 1'b0, 4'(1 << i));
            cyc((i + 1) * TD - 5);
            chk(adjEnable === 1'b1, "stage early low");
            cyc(TD + 25);
            chk(adjEnable === 1'b0, "stage no drop");
        end
    endtask
    task automatic t_capture;
        src(1'b0, 1'b1, 4'h3);
        cyc(12);
        src(1'b0, 1'b0, 4'h3);
        cyc(8);
        src(1'b0, 1'b0, 4'h0);
        cyc(30);
        chk(adjEnable === 1'b1, "selects recaptured");
        chk(timeChanged === 1'b1, "change flag missing");
        cyc(40);
        chk(adjEnable === 1'b0, "summed delay wrong");
        chk(timeChanged === 1'b1, "change flag lost");
        src(1'b0, 1'b1, 4'h3);
        cyc(12);
        chk(timeChanged === 1'b0, "change flag not cleared");
    endtask
    task automatic t_cfg;
        wr(ADDR_STAGE0, 32'hEA54, RESP_OKAY);
        rd(ADDR_STATUS, RESP_OKAY, rdat);
        chk(rdat[ST_CFGERR_BIT] === 1'b0, "total at limit refused");
        wr(ADDR_STAGE0, 32'hEA55, RESP_OKAY);
        rd(ADDR_STATUS, RESP_OKAY, rdat);
        chk(rdat[ST_CFGERR_BIT] === 1'b1, "total over limit accepted");
        src(1'b0, 1'b0, 4'h3);
        cyc(12);
        chk(adjEnable === 1'b0, "bad total still delays");
        src(1'b0, 1'b1, 4'h3);
        wr(ADDR_STAGE0, 32'h2, RESP_OKAY);
    endtask
    task automatic t_stop;
        cyc(12);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        src(1'b0, 1'b0, 4'h3);
        cyc(20);
        chk(adjEnable === 1'b1, "output moved in stop");
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        cyc(10);
        chk(adjEnable === 1'b0, "first run cycle not low");
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_fix();
        t_adj();
        t_capture();
        t_cfg();
        t_stop();
        end_sim();
    end
endmodule
